//--- rtl/fault_prop_pkg.sv
// shared constants and carrier types for the fault propagation sequencer
package fault_prop_pkg;
    localparam int  clk_rate_hz        = 10_000_000;
    localparam int  restart_ms         = 130;
    localparam int  restart_cycles     = (restart_ms * (clk_rate_hz / 1000));
    localparam int  line_filter_cycles = 4;
    localparam int  group_min          = 1;
    localparam int  group_max          = 32;
    localparam logic [1:0] latch_reset = 2'h0;

    // fault and error class inputs sampled from the protection comparators
    typedef struct packed {
        logic overcurrent_protection;
        logic undervoltage_protection;
        logic overtemp_protection;
        logic tracking_protection;
        logic overvoltage_error;
    } detect_t;

    // protection settings from the configuration registers
    typedef struct packed {
        logic prop_enable;
        logic non_latching;
        logic tracking_enable;
    } propagation_config_t;

    // switch and ramp commands toward the power stage
    typedef struct packed {
        logic regular_off;
        logic fast_off;
        logic low_side_on;
        logic ramp_up;
    } stage_cmd_t;

    typedef enum logic [2:0] {
        st_run      = 3'b000,
        st_ramp_off = 3'b001,
        st_fast_off = 3'b010,
        st_wait     = 3'b011,
        st_latched  = 3'b100
    } seq_state_t;
endpackage : fault_prop_pkg

//--- rtl/line_filter.sv
// synchroniser and agreement filter for the shared group fault line
`timescale 1ns/100ps
`default_nettype none
module line_filter #(
    parameter int depth = 4
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    input  wire logic line_in,
    output logic      line_low
);
    logic [2:0]             sync_reg;
    logic [$clog2(depth+1)-1:0] cnt_reg;

    // three stages; only the second and third are compared
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync_reg <= 3'h7;
        end else if (clk_en) begin
            sync_reg <= {sync_reg[1:0], line_in};
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg  <= '0;
            line_low <= 1'b0;
        end else if (clk_en) begin
            if (!sync_reg[1] && !sync_reg[2]) begin
                if (cnt_reg == depth[$clog2(depth+1)-1:0]) begin
                    line_low <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end else begin
                cnt_reg  <= '0;
                line_low <= 1'b0;
            end
        end
    end
endmodule : line_filter
`default_nettype wire

//--- rtl/fault_propagation_sequencer.sv
// fault and error shutdown, group line propagation and restart timing
//
// Behaviour
// RULE_01 - group holds one to thirty-two converters
// RULE_02 - line driven only when propagation enabled
// RULE_03 - own fault pulls group line low
// RULE_04 - low line without own fault: turn off
// RULE_05 - manager watches at most four group lines
// RULE_06 - manager relays low line to other groups
// RULE_07 - manager may kill front end on error
// RULE_08 - propagated fault gives regular ramped turn-off
// RULE_09 - originator picks turn-off by fault type
// RULE_10 - propagated error gives immediate fast turn-off
// RULE_11 - originating error: fast off, low side on
// RULE_12 - non-latching fault retries every 130 ms
// RULE_13 - interval runs from zero output to ramp
// RULE_14 - regular off honours delay and slew
// RULE_15 - overcurrent, overtemp, undervoltage, tracking are faults
// RULE_16 - overvoltage is an error class event
// RULE_17 - latching off until clear or cycle
// RULE_18 - group line synchronised and filtered first
// RULE_19 - release line only when restart begins
`timescale 1ns/100ps
`default_nettype none
module fault_propagation_sequencer
    import fault_prop_pkg::*;
#(
    parameter int restart_count = restart_cycles,
    parameter int filter_depth  = line_filter_cycles
) (
    input  wire logic                                mclk,
    input  wire logic                                reset_n,
    input  wire logic                                clk_en,
    input  wire fault_prop_pkg::detect_t             detect,
    input  wire fault_prop_pkg::propagation_config_t cfg,
    input  wire logic                                prop_error_in,
    input  wire logic                                ramp_done,
    input  wire logic                                status_clear,
    input  wire logic                                turn_on_cmd,
    input  wire logic                                group_line_in,
    output logic                                     group_line_out,
    output logic                                     group_line_oe,
    output fault_prop_pkg::stage_cmd_t               stage_cmd,
    output logic                                     fault_flag,
    output logic                                     error_flag
);
    seq_state_t           state_reg;
    seq_state_t           state_next;
    logic [31:0]          wait_reg;
    logic                 line_low;
    logic                 on_d_reg;
    logic                 own_fault;
    logic                 own_fast;
    logic                 own_error;
    logic                 hit_line;
    logic                 wait_done;
    logic                 mask_reg;

    // filter does not depend on how many members share the line [RULE_01]
    line_filter #(
        .depth    (filter_depth)
    ) u_filter (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .line_in  (group_line_in),
        .line_low (line_low)          // [RULE_18]
    );

    assign own_error = detect.overvoltage_error;                                    // [RULE_16]
    assign own_fault = detect.overcurrent_protection | detect.undervoltage_protection
                     | detect.overtemp_protection
                     | (detect.tracking_protection & cfg.tracking_enable);          // [RULE_15]
    // overcurrent and tracking cut both switches, undervoltage and overtemp ramp down
    assign own_fast  = detect.overcurrent_protection
                     | (detect.tracking_protection & cfg.tracking_enable);          // [RULE_09]
    // our own drive is seen on the line, so only foreign lows count in run
    // the filtered low lags our release by the sync delay, so mask it until the line reads high
    assign hit_line  = line_low & ~group_line_oe & ~mask_reg;                       // [RULE_04]
    assign wait_done = (wait_reg == 32'(restart_count - 1));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            st_run: begin
                if (own_error) begin
                    state_next = st_fast_off;                                      // [RULE_11]
                end else if (own_fault) begin
                    state_next = own_fast ? st_fast_off : st_ramp_off;             // [RULE_09]
                end else if (hit_line) begin
                    state_next = prop_error_in ? st_fast_off : st_ramp_off;        // [RULE_08] [RULE_10]
                end
            end
            st_ramp_off: begin
                if (ramp_done) begin
                    state_next = st_wait;                                          // [RULE_14]
                end
            end
            st_fast_off: begin
                state_next = st_wait;
            end
            st_wait: begin
                if (!cfg.non_latching && (fault_flag || error_flag)) begin
                    state_next = st_latched;                                       // [RULE_17]
                end else if (wait_done) begin
                    state_next = st_run;                                           // [RULE_12] [RULE_13]
                end
            end
            st_latched: begin
                if (status_clear || (turn_on_cmd && !on_d_reg)) begin
                    state_next = st_run;                                           // [RULE_17]
                end
            end
            default: begin
                state_next = st_run;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= st_run;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            on_d_reg <= 1'b0;
        end else if (clk_en) begin
            on_d_reg <= turn_on_cmd;
        end
    end

    // limitation: a peer still holding the line at our retry is seen only after it lets go
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= 1'b0;
        end else if (clk_en) begin
            if (group_line_oe) begin
                mask_reg <= 1'b1;
            end else if (!line_low) begin
                mask_reg <= 1'b0;                                                  // [RULE_18]
            end
        end
    end

    // interval counts only once output has reached zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wait_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            if (state_reg == st_wait && !wait_done) begin
                wait_reg <= wait_reg + 32'h0000_0001;                              // [RULE_13]
            end else if (state_reg != st_wait) begin
                wait_reg <= 32'h0000_0000;
            end
        end
    end

    // sticky class flags; new detection wins over a clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fault_flag <= 1'b0;
            error_flag <= 1'b0;
        end else if (clk_en) begin
            if (state_reg == st_run && own_error) begin
                error_flag <= 1'b1;
            end else if (status_clear) begin
                error_flag <= 1'b0;
            end
            if (state_reg == st_run && own_fault && !own_error) begin
                fault_flag <= 1'b1;
            end else if (status_clear) begin
                fault_flag <= 1'b0;
            end
        end
    end

    // line is held from our own shutdown until the retry starts
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            group_line_oe <= 1'b0;
            group_line_out <= 1'b0;
        end else if (clk_en) begin
            group_line_out <= 1'b0;
            if (state_reg == st_run && cfg.prop_enable && (own_error || own_fault)) begin
                group_line_oe <= 1'b1;                                             // [RULE_02] [RULE_03]
            end else if (state_next == st_run && state_reg != st_run) begin
                group_line_oe <= 1'b0;                                             // [RULE_19]
            end else if (!cfg.prop_enable) begin
                group_line_oe <= 1'b0;                                             // [RULE_02]
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stage_cmd <= '0;
        end else if (clk_en) begin
            stage_cmd.regular_off <= (state_next == st_ramp_off);                 // [RULE_14]
            stage_cmd.fast_off    <= (state_next == st_fast_off)
                                   || ((state_next == st_wait || state_next == st_latched)
                                       && stage_cmd.fast_off);                    // [RULE_10]
            stage_cmd.low_side_on <= (state_next != st_run) && (error_flag
                                   || (state_reg == st_run && own_error));        // [RULE_11]
            stage_cmd.ramp_up     <= (state_next == st_run);
        end
    end

    a_line_needs_enable: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(group_line_oe) |-> $past(cfg.prop_enable))                          // [RULE_02]
        else $error("group line driven while propagation disabled");
    a_fault_pulls_line: assert property (@(posedge mclk) disable iff (!reset_n)
        (clk_en && state_reg == st_run && cfg.prop_enable && own_fault) |=> group_line_oe) // [RULE_03]
        else $error("own fault did not pull line");
    a_error_low_side: assert property (@(posedge mclk) disable iff (!reset_n)
        (clk_en && state_reg == st_run && own_error) |=> stage_cmd.fast_off && stage_cmd.low_side_on) // [RULE_11]
        else $error("error did not give fast off with low side");
    a_prop_regular: assert property (@(posedge mclk) disable iff (!reset_n)
        (clk_en && state_reg == st_run && !own_fault && !own_error && hit_line && !prop_error_in)
        |=> stage_cmd.regular_off)                                                // [RULE_08]
        else $error("propagated fault not regular off");
    a_prop_fast: assert property (@(posedge mclk) disable iff (!reset_n)
        (clk_en && state_reg == st_run && !own_fault && !own_error && hit_line && prop_error_in)
        |=> stage_cmd.fast_off && !stage_cmd.low_side_on)                         // [RULE_10]
        else $error("propagated error not fast off");
    a_wait_length: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_reg == st_run && $past(state_reg) == st_wait) |-> $past(wait_done)) // [RULE_12] [RULE_13]
        else $error("restart before interval elapsed");
    a_release_at_restart: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(group_line_oe) && $past(cfg.prop_enable) |-> state_reg == st_run)  // [RULE_19]
        else $error("line released outside restart");
    a_latch_holds: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_reg == st_latched && !status_clear && !turn_on_cmd) |=> state_reg == st_latched) // [RULE_17]
        else $error("latched state left without clear");
    a_ramp_waits: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_reg == st_ramp_off && !ramp_done) |=> state_reg == st_ramp_off)   // [RULE_14]
        else $error("regular off ended before ramp finished");
endmodule : fault_propagation_sequencer
`default_nettype wire

//--- tb/group_line_model.sv
// model of the shared group fault line with peer converters and the power manager relay
`timescale 1ns/100ps
`default_nettype none
module group_line_model (
    input  wire logic mclk,
    input  wire logic dut_oe,
    input  wire logic peer_pull,
    input  wire logic other_group_low,
    input  wire logic relay_enable,
    input  wire logic relay_error,
    output logic      line,
    output logic      front_end_off
);
    logic relay_pull_reg = 1'b0;
    initial front_end_off = 1'b0;
    // pull-up: a released line reads high, never the last driven value
    assign line = !(dut_oe || peer_pull || relay_pull_reg);
    // relay lags one clock since the manager samples its lines
    always @(posedge mclk) begin
        relay_pull_reg <= relay_enable && other_group_low;
        front_end_off  <= relay_enable && other_group_low && relay_error;
    end
endmodule : group_line_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the fault propagation sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import fault_prop_pkg::*;
    localparam int rc = 50;
    logic mclk, reset_n, prop_error_in, ramp_done, status_clear, turn_on_cmd;
    logic clk_en;
    logic peer_pull, other_low, line, oe, line_out, fault_flag, error_flag, fe_off;
    detect_t             detect;
    propagation_config_t cfg;
    stage_cmd_t          cmd;
    int                  mismatches = 0;
    int                  n_compared = 0;
    int                  k, n;
    logic [31:0]         seed = 32'h0000_91a0;

    fault_propagation_sequencer #(.restart_count(rc), .filter_depth(4)) DUT (
        .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .detect(detect), .cfg(cfg),
        .prop_error_in(prop_error_in), .ramp_done(ramp_done), .status_clear(status_clear),
        .turn_on_cmd(turn_on_cmd), .group_line_in(line), .group_line_out(line_out),
        .group_line_oe(oe), .stage_cmd(cmd), .fault_flag(fault_flag), .error_flag(error_flag));
    group_line_model peers (
        .mclk(mclk), .dut_oe(oe), .peer_pull(peer_pull), .other_group_low(other_low),
        .relay_enable(1'b1), .relay_error(prop_error_in), .line(line), .front_end_off(fe_off));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // classes 0 overcurrent, 3 tracking, 4 overvoltage switch off at once
    function automatic logic is_fast(input int c);
        return (c == 0 || c == 3 || c == 4);
    endfunction : is_fast

    task automatic stop_test();
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %b seen %b", name, exp, got);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge mclk);
    endtask : cyc
    // bounded wait for the next ramp-up, sampled away from the edge
    task automatic wait_ramp(input int lim, output int c);
        c = 0;
        @(negedge mclk);
        while (cmd.ramp_up !== 1'b1 && c < lim) begin
            @(negedge mclk);
            c++;
        end
        if (c >= lim) begin
            chk("ramp_up wait", 1'b1, 1'b0);
            stop_test();
        end
        @(posedge mclk);
    endtask : wait_ramp

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        reset_n = 1'b0;
        detect = '0;
        cfg = 3'h7;
        {prop_error_in, ramp_done, status_clear, peer_pull, other_low} = '0;
        turn_on_cmd = 1'b1;
        clk_en = 1'b1;
        cyc(2);
        reset_n <= 1'b1;
        cyc(2);
        @(negedge mclk);
        chk("ramp_up", 1'b1, cmd.ramp_up);
        chk("group_line_oe", 1'b0, oe);
        // every fault and error class, propagation enable drawn at random
        for (k = 0; k < 5; k++) begin
            seed = xs(seed);
            @(posedge mclk);
            cfg.prop_enable <= seed[0];
            @(posedge mclk);
            detect <= detect_t'(5'h10 >> k);
            cyc(3);
            @(negedge mclk);
            chk("fast_off", is_fast(k), cmd.fast_off);
            chk("regular_off", !is_fast(k), cmd.regular_off);
            chk("low_side_on", k == 4, cmd.low_side_on);
            chk("group_line_oe", seed[0], oe);
            chk("error_flag", k == 4, error_flag);
            @(posedge mclk);
            detect <= '0;
            ramp_done <= !is_fast(k);
            @(posedge mclk);
            ramp_done <= 1'b0;
            status_clear <= 1'b1;
            @(posedge mclk);
            status_clear <= 1'b0;
            wait_ramp(rc + 20, n);
            chk("restart_interval", 1'b1, n >= rc - 6 && n <= rc + 4);
            chk("group_line_oe", 1'b0, oe);
            chk("fast_off", 1'b0, cmd.fast_off);
        end
        // a one-cycle glitch on the line is filtered out
        @(posedge mclk);
        peer_pull <= 1'b1;
        @(posedge mclk);
        peer_pull <= 1'b0;
        cyc(10);
        @(negedge mclk);
        chk("ramp_up", 1'b1, cmd.ramp_up);
        // clock enable low freezes the sequencer even with a fault present
        @(posedge mclk);
        clk_en <= 1'b0;
        detect <= detect_t'(5'h10);
        cyc(3);
        @(negedge mclk);
        chk("frozen ramp_up", 1'b1, cmd.ramp_up);
        chk("frozen fault_flag", 1'b0, fault_flag);
        @(posedge mclk);
        detect <= '0;
        @(posedge mclk);
        clk_en <= 1'b1;
        cyc(2);
        // propagated fault from a peer, then propagated error relayed by the manager
        for (k = 0; k < 2; k++) begin
            @(posedge mclk);
            prop_error_in <= k[0];
            peer_pull <= !k[0];
            other_low <= k[0];
            cyc(12);
            @(negedge mclk);
            chk("regular_off", !k[0], cmd.regular_off);
            chk("fast_off", k[0], cmd.fast_off);
            chk("low_side_on", 1'b0, cmd.low_side_on);
            chk("group_line_oe", 1'b0, oe);
            chk("front_end_off", k[0], fe_off);
            @(posedge mclk);
            {peer_pull, other_low, prop_error_in} <= '0;
            ramp_done <= !k[0];
            @(posedge mclk);
            ramp_done <= 1'b0;
            wait_ramp(rc + 40, n);
        end
        // latching undervoltage stays off until flags clear or turn-on cycles
        @(posedge mclk);
        cfg.non_latching <= 1'b0;
        detect <= detect_t'(5'h08);
        cyc(3);
        detect <= '0;
        ramp_done <= 1'b1;
        @(posedge mclk);
        ramp_done <= 1'b0;
        cyc(rc + 20);
        @(negedge mclk);
        chk("ramp_up", 1'b0, cmd.ramp_up);
        chk("fault_flag", 1'b1, fault_flag);
        @(posedge mclk);
        status_clear <= 1'b1;
        turn_on_cmd <= 1'b0;
        @(posedge mclk);
        status_clear <= 1'b0;
        turn_on_cmd <= 1'b1;
        wait_ramp(rc + 40, n);
        chk("ramp_up", 1'b1, cmd.ramp_up);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
